// File: fsktc_pkg.sv
// shared constants of the fsk tone control block
// assumes a 125 MHz system clock and an AHB-Lite register bus
package fsktc_pkg;
    // ----------------------------------------------------
    // clock and tone timing
    // ----------------------------------------------------
    localparam int CLK_HZ      = 125_000_000;
    localparam int TONE_ORIG_SPACE_HZ = 1070;
    localparam int TONE_ORIG_MARK_HZ  = 1270;
    localparam int TONE_ANS_SPACE_HZ  = 2025;
    localparam int TONE_ANS_MARK_HZ   = 2225;
    localparam int TONE_OVERSAMPLE    = 16;
    localparam int BAUD_HZ            = 300;
    // nearest integer of clk / (16 * tone)
    localparam int DIV_ORIG_SPACE = (CLK_HZ + TONE_OVERSAMPLE * TONE_ORIG_SPACE_HZ / 2)
                                    / (TONE_OVERSAMPLE * TONE_ORIG_SPACE_HZ);
    localparam int DIV_ORIG_MARK  = (CLK_HZ + TONE_OVERSAMPLE * TONE_ORIG_MARK_HZ / 2)
                                    / (TONE_OVERSAMPLE * TONE_ORIG_MARK_HZ);
    localparam int DIV_ANS_SPACE  = (CLK_HZ + TONE_OVERSAMPLE * TONE_ANS_SPACE_HZ / 2)
                                    / (TONE_OVERSAMPLE * TONE_ANS_SPACE_HZ);
    localparam int DIV_ANS_MARK   = (CLK_HZ + TONE_OVERSAMPLE * TONE_ANS_MARK_HZ / 2)
                                    / (TONE_OVERSAMPLE * TONE_ANS_MARK_HZ);
    localparam int BAUD_CYCLES    = CLK_HZ / BAUD_HZ;
    localparam int DIV_W          = 16;
    localparam int BAUD_W         = 20;
    localparam int LOOP_STAGES    = 4;
    // ----------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_TXDATA = 4'h8;
    localparam logic [3:0] ADDR_DIV    = 4'hC;
    // control fields
    localparam int CTRL_REGSEL   = 0;
    localparam int CTRL_TXBIT    = 1;
    localparam int CTRL_ORIG     = 2;
    localparam int CTRL_SQUELCH  = 3;
    localparam int CTRL_LOOPBACK = 4;
    localparam int CTRL_STREAM   = 5;
    localparam int CTRL_W        = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // status fields
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_PHASE_LSB = 4;
    localparam int STAT_CARRIER   = 8;
    localparam int STAT_RXBIT     = 9;
    localparam int STAT_LEVEL_LSB = 10;
    localparam int STAT_OSC       = 12;
    localparam int STAT_BAND_HIGH = 13;
    // ----------------------------------------------------
    // modes and sine staircase
    // ----------------------------------------------------
    typedef enum logic [3:0] {
        MODE_NORMAL   = 4'b0001,
        MODE_SQUELCH  = 4'b0010,
        MODE_LOOPBACK = 4'b0100,
        MODE_POWERDN  = 4'b1000
    } fsktc_mode_t;
    localparam logic [3:0] TAP_MID = 4'h8;
    // level per phase step, entry 0 in the low nibble
    localparam logic [63:0] SINE_TABLE = 64'h521_0_125_8_A_DEF_ED_A_8;
endpackage

// File: fsktc_sine_rom.sv
// sixteen-entry sine staircase, phase step to DAC tap level
// assumes the caller holds phase stable and reads one cycle later
`timescale 1ns/1ps
module fsktc_sine_rom (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] phase,
    output logic      [3:0] level
);
    // ----------------------------------------------------
    // registered lookup
    // ----------------------------------------------------
    logic [3:0] level_q;

    // read data leaves a register so the tap decode stays short
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_q <= fsktc_pkg::TAP_MID;
        end else begin
            level_q <= fsktc_pkg::SINE_TABLE[{phase, 2'b00} +: 4];
        end
    end

    assign level = level_q;
endmodule

// File: fsktc_top.sv
// fsk modem tone control: mode decode, dual-modulus tone divider,
// phase counter, sine taps, transmit bit buffer and AHB-Lite registers
// assumes control and receive pins are asynchronous to clk
`timescale 1ns/1ps
module fsktc_top #(
    parameter logic [15:0] DIV_OS    = 16'(fsktc_pkg::DIV_ORIG_SPACE),
    parameter logic [15:0] DIV_OM    = 16'(fsktc_pkg::DIV_ORIG_MARK),
    parameter logic [15:0] DIV_AS    = 16'(fsktc_pkg::DIV_ANS_SPACE),
    parameter logic [15:0] DIV_AM    = 16'(fsktc_pkg::DIV_ANS_MARK),
    parameter logic [19:0] BAUD_DIV  = 20'(fsktc_pkg::BAUD_CYCLES),
    parameter int          FIFO_W    = 1
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    // host pins
    input  wire logic        txBitPin,
    input  wire logic        originatePin,
    input  wire logic        txSquelchPin,
    input  wire logic        loopbackSelectPin,
    input  wire logic        crystalSenseClampPin,
    // demodulator side
    input  wire logic        demodBitPin,
    input  wire logic        demodCarrierPin,
    output logic             demodBandHigh,
    output logic             loopRouteEn,
    // line and receive outputs with enables
    output logic [15:0]      dacTap,
    output logic             dacTapOe,
    output logic             lineDriverEn,
    output logic             rxBitOut,
    output logic             rxBitOe,
    output logic             carrierFoundN,
    output logic             carrierFoundOe,
    output logic             oscRunning,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);
    // ----------------------------------------------------
    // helpers
    // ----------------------------------------------------
    function automatic fsktc_pkg::fsktc_mode_t decodeMode(input logic sq, input logic lb);
        if (sq && lb) begin
            decodeMode = fsktc_pkg::MODE_POWERDN;
        end else if (sq) begin
            decodeMode = fsktc_pkg::MODE_SQUELCH;
        end else if (lb) begin
            decodeMode = fsktc_pkg::MODE_LOOPBACK;
        end else begin
            decodeMode = fsktc_pkg::MODE_NORMAL;
        end
    endfunction

    function automatic logic [15:0] toneDiv(input logic orig, input logic mark);
        logic [15:0] d;
        d = 16'h0000;
        case ({orig, mark})
            2'b11:   d = DIV_OM;
            2'b10:   d = DIV_OS;
            2'b01:   d = DIV_AM;
            default: d = DIV_AS;
        endcase
        toneDiv = d;
    endfunction

    // ----------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------
    logic [6:0] syncA_q;
    logic [6:0] syncB_q;

    // two flops per pin, only the second stage is used
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncA_q <= 7'h00;
            syncB_q <= 7'h00;
        end else begin
            syncA_q <= {crystalSenseClampPin, demodCarrierPin, demodBitPin,
                        loopbackSelectPin, txSquelchPin, originatePin, txBitPin};
            syncB_q <= syncA_q;
        end
    end

    // ----------------------------------------------------
    // control register and mode decode
    // ----------------------------------------------------
    logic [5:0]            ctrl_q;
    logic                  selTxBit;
    logic                  selOrig;
    logic                  selSquelch;
    logic                  selLoop;
    fsktc_pkg::fsktc_mode_t mode;
    logic                  oscRun_q;
    logic                  active;

    // register bits stand in for the pins when software owns control
    assign selOrig    = ctrl_q[fsktc_pkg::CTRL_REGSEL] ? ctrl_q[fsktc_pkg::CTRL_ORIG] : syncB_q[1];
    assign selSquelch = ctrl_q[fsktc_pkg::CTRL_REGSEL] ? ctrl_q[fsktc_pkg::CTRL_SQUELCH] : syncB_q[2];
    assign selLoop    = ctrl_q[fsktc_pkg::CTRL_REGSEL] ? ctrl_q[fsktc_pkg::CTRL_LOOPBACK] : syncB_q[3];
    // either select low keeps the chip out of power-down, both high power it down
    assign mode       = decodeMode(selSquelch, selLoop);
    assign active     = (mode != fsktc_pkg::MODE_POWERDN) && oscRun_q;

    // oscillator keeps running in power-down, stops only when clamped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oscRun_q <= 1'b1;
        end else begin
            oscRun_q <= !syncB_q[6];
        end
    end

    // ----------------------------------------------------
    // transmit bit buffer, drained once per baud
    // ----------------------------------------------------
    logic [FIFO_W-1:0] fifoMem_q [2];
    logic              fifoWr_q;
    logic              fifoRd_q;
    logic [1:0]        fifoLevel_q;
    logic              fifoInValid;
    logic              fifoInReady;
    logic              fifoOutValid;
    logic              fifoOutReady;
    logic [19:0]       baudCnt_q;
    logic              baudTick_q;
    logic              streamBit_q;

    assign fifoInReady  = (fifoLevel_q != 2'd2);
    assign fifoOutValid = (fifoLevel_q != 2'd0);
    // squelch and power-down stall the drain so queued bits wait
    assign fifoOutReady = baudTick_q && ctrl_q[fsktc_pkg::CTRL_STREAM]
                          && active && (mode != fsktc_pkg::MODE_SQUELCH);

    // baud enable divider
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baudCnt_q  <= 20'h00000;
            baudTick_q <= 1'b0;
        end else if (baudCnt_q == BAUD_DIV - 20'h00001) begin
            baudCnt_q  <= 20'h00000;
            baudTick_q <= 1'b1;
        end else begin
            baudCnt_q  <= baudCnt_q + 20'h00001;
            baudTick_q <= 1'b0;
        end
    end

    // two-entry buffer; push and pop in one cycle keep the level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fifoMem_q[0] <= '0;
            fifoMem_q[1] <= '0;
            fifoWr_q     <= 1'b0;
            fifoRd_q     <= 1'b0;
            fifoLevel_q  <= 2'd0;
            streamBit_q  <= 1'b1;
        end else begin
            if (fifoInValid && fifoInReady) begin
                fifoMem_q[fifoWr_q] <= hwdata[FIFO_W-1:0];
                fifoWr_q            <= !fifoWr_q;
            end
            if (fifoOutValid && fifoOutReady) begin
                streamBit_q <= fifoMem_q[fifoRd_q][0];
                fifoRd_q    <= !fifoRd_q;
            end
            fifoLevel_q <= fifoLevel_q + 2'(fifoInValid && fifoInReady)
                           - 2'(fifoOutValid && fifoOutReady);
        end
    end

    assign selTxBit = ctrl_q[fsktc_pkg::CTRL_STREAM] ? streamBit_q :
                      ctrl_q[fsktc_pkg::CTRL_REGSEL] ? ctrl_q[fsktc_pkg::CTRL_TXBIT] : syncB_q[0];

    // ----------------------------------------------------
    // dual-modulus divider and phase counter
    // ----------------------------------------------------
    logic [15:0] divCnt_q;
    logic [15:0] divActive_q;
    logic        toneTick_q;
    logic [3:0]  phase_q;
    logic [3:0]  tapLevel;

    // divisor is taken only at terminal count so a period never tears
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_q    <= 16'h0000;
            divActive_q <= 16'h0001;
            toneTick_q  <= 1'b0;
        end else if (!active) begin
            toneTick_q  <= 1'b0;
        end else if (divCnt_q >= divActive_q - 16'h0001) begin
            divCnt_q    <= 16'h0000;
            divActive_q <= toneDiv(selOrig, selTxBit);
            toneTick_q  <= 1'b1;
        end else begin
            divCnt_q    <= divCnt_q + 16'h0001;
            toneTick_q  <= 1'b0;
        end
    end

    // the counter runs on across divisor changes for coherent keying
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 4'h0;
        end else if (toneTick_q) begin
            phase_q <= phase_q + 4'h1;
        end
    end

    fsktc_sine_rom u_rom (
        .clk    (clk),
        .resetn (resetn),
        .phase  (phase_q),
        .level  (tapLevel)
    );

    // ----------------------------------------------------
    // line outputs
    // ----------------------------------------------------
    logic [15:0] dacTap_q;
    logic        dacTapOe_q;
    logic        lineDrv_q;
    logic        loopRoute_q;

    // squelch parks the ladder at mid tap, driver stays enabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dacTap_q    <= 16'h0000;
            dacTapOe_q  <= 1'b0;
            lineDrv_q   <= 1'b0;
            loopRoute_q <= 1'b0;
        end else begin
            if (mode == fsktc_pkg::MODE_SQUELCH) begin
                dacTap_q <= 16'h0001 << fsktc_pkg::TAP_MID;
            end else begin
                dacTap_q <= 16'h0001 << tapLevel;
            end
            dacTapOe_q  <= active;
            lineDrv_q   <= active;
            loopRoute_q <= active && (mode == fsktc_pkg::MODE_LOOPBACK);
        end
    end

    // ----------------------------------------------------
    // receive path
    // ----------------------------------------------------
    logic [3:0] loopDelay_q;
    logic       bandHigh_q;
    logic       rxBit_q;
    logic       carrierN_q;
    logic       rxOe_q;

    // looped bits ride a short delay line clocked by tone ticks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loopDelay_q <= 4'hF;
        end else if (toneTick_q) begin
            loopDelay_q <= {loopDelay_q[2:0], selTxBit};
        end
    end

    // demodulator band and receive outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bandHigh_q <= 1'b0;
            rxBit_q    <= 1'b1;
            carrierN_q <= 1'b1;
            rxOe_q     <= 1'b0;
        end else begin
            rxOe_q <= active;
            if (mode == fsktc_pkg::MODE_LOOPBACK) begin
                bandHigh_q <= !selOrig;
                carrierN_q <= 1'b0;
                rxBit_q    <= loopDelay_q[fsktc_pkg::LOOP_STAGES-1];
            end else begin
                bandHigh_q <= selOrig;
                carrierN_q <= !syncB_q[5];
                // no carrier clamps the data high
                rxBit_q    <= syncB_q[5] ? syncB_q[4] : 1'b1;
            end
        end
    end

    // ----------------------------------------------------
    // AHB-Lite slave, one wait state per transfer, more while a TXDATA write meets a full buffer
    // ----------------------------------------------------
    logic        dpValid_q;
    logic        dpWrite_q;
    logic        dpMapped_q;
    logic [3:0]  dpAddr_q;
    logic        hready_q;
    logic [31:0] hrdata_q;
    logic        hresp_q;
    logic        addrTake;
    logic        dpTxWrite;
    logic        dpDone;
    logic [31:0] statusWord;

    assign addrTake    = hsel && hready && htrans[1];
    assign dpTxWrite   = dpValid_q && dpWrite_q && dpMapped_q
                         && (dpAddr_q == fsktc_pkg::ADDR_TXDATA);
    // a full buffer holds the write in its data phase
    assign fifoInValid = dpTxWrite;
    assign dpDone      = dpValid_q && (!dpTxWrite || fifoInReady);
    assign statusWord  = {18'h00000, bandHigh_q, oscRun_q, fifoLevel_q,
                          rxBit_q, !carrierN_q, phase_q, 4'(mode)};

    // address phase capture and ready
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dpValid_q  <= 1'b0;
            dpWrite_q  <= 1'b0;
            dpMapped_q <= 1'b0;
            dpAddr_q   <= 4'h0;
            hready_q   <= 1'b1;
            hresp_q    <= 1'b0;
        end else if (addrTake) begin
            dpValid_q  <= 1'b1;
            dpWrite_q  <= hwrite;
            dpMapped_q <= (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'b00);
            dpAddr_q   <= haddr[3:0];
            hready_q   <= 1'b0;
        end else if (dpDone) begin
            dpValid_q  <= 1'b0;
            hready_q   <= 1'b1;
        end
    end

    // register writes and read data; unmapped reads give zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q   <= fsktc_pkg::CTRL_RESET;
            hrdata_q <= 32'h00000000;
        end else if (dpDone) begin
            hrdata_q <= 32'h00000000;
            if (dpWrite_q && dpMapped_q && dpAddr_q == fsktc_pkg::ADDR_CTRL) begin
                ctrl_q <= hwdata[fsktc_pkg::CTRL_W-1:0];
            end
            if (!dpWrite_q && dpMapped_q) begin
                case (dpAddr_q)
                    fsktc_pkg::ADDR_CTRL:   hrdata_q <= {26'h0000000, ctrl_q};
                    fsktc_pkg::ADDR_STATUS: hrdata_q <= statusWord;
                    fsktc_pkg::ADDR_DIV:    hrdata_q <= {16'h0000, divActive_q};
                    default:                hrdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------
    // outputs
    // ----------------------------------------------------
    assign dacTap         = dacTap_q;
    assign dacTapOe       = dacTapOe_q;
    assign lineDriverEn   = lineDrv_q;
    assign loopRouteEn    = loopRoute_q;
    assign demodBandHigh  = bandHigh_q;
    assign rxBitOut       = rxBit_q;
    assign rxBitOe        = rxOe_q;
    assign carrierFoundN  = carrierN_q;
    assign carrierFoundOe = rxOe_q;
    assign oscRunning     = oscRun_q;
    assign hreadyout      = hready_q;
    assign hrdata         = hrdata_q;
    assign hresp          = hresp_q;
endmodule

// File: fsktc_monitor.sv
// checker on the pins of the tone control top
// assumes pins reach the outputs within six clock edges
`timescale 1ns/1ps
module fsktc_monitor #(
    parameter logic [15:0] DIV_OS = 16'h000A
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        originatePin,
    input wire logic        txSquelchPin,
    input wire logic        loopbackSelectPin,
    input wire logic        crystalSenseClampPin,
    input wire logic        demodCarrierPin,
    input wire logic        demodBandHigh,
    input wire logic        loopRouteEn,
    input wire logic [15:0] dacTap,
    input wire logic        dacTapOe,
    input wire logic        lineDriverEn,
    input wire logic        rxBitOut,
    input wire logic        rxBitOe,
    input wire logic        carrierFoundN,
    input wire logic        carrierFoundOe,
    input wire logic        oscRunning
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // ----------------------------
    // pin decode and tap step count
    // ----------------------------
    logic        run, pd, sqOnly, lbOnly, norm;
    logic [15:0] holdCnt_q, prevTap_q;
    assign run    = !crystalSenseClampPin;
    assign pd     = txSquelchPin && loopbackSelectPin;
    assign sqOnly = run && txSquelchPin && !loopbackSelectPin;
    assign lbOnly = run && loopbackSelectPin && !txSquelchPin;
    assign norm   = run && !txSquelchPin && !loopbackSelectPin;
    // cleared outside normal tone, so a parked tap never trips it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            holdCnt_q <= 16'h0000;
            prevTap_q <= 16'h0000;
        end else begin
            prevTap_q <= dacTap;
            holdCnt_q <= (dacTap != prevTap_q || !norm) ? 16'h0000 : holdCnt_q + 16'h0001;
        end
    end
    a_pd_float: assert property ((pd)[*6] |-> !dacTapOe && !rxBitOe && !carrierFoundOe && !lineDriverEn)
        else $error("output driven in power-down");
    a_osc_run: assert property ((pd && run)[*6] |-> oscRunning)
        else $error("oscillator stopped in power-down");
    a_osc_stop: assert property ((crystalSenseClampPin)[*6] |-> !oscRunning)
        else $error("oscillator runs while clamped");
    a_sq_park: assert property ((sqOnly)[*6] |-> dacTap == 16'h0100 && dacTapOe && lineDriverEn)
        else $error("squelch did not park the tone");
    a_lb_route: assert property ((lbOnly && originatePin)[*6] |-> !carrierFoundN && loopRouteEn && !demodBandHigh && lineDriverEn)
        else $error("loopback state wrong");
    a_band_pair: assert property ((!loopbackSelectPin && $stable(originatePin))[*6] |-> demodBandHigh == originatePin)
        else $error("demodulator on wrong tone pair");
    a_rx_idle: assert property ((run && !demodCarrierPin && !loopbackSelectPin)[*6] |-> rxBitOut)
        else $error("receive bit low without carrier");
    a_tap_step: assert property ((norm)[*8] |-> holdCnt_q <= DIV_OS + 16'h0008)
        else $error("tap step too slow");
endmodule

bind fsktc_top fsktc_monitor #(.DIV_OS(DIV_OS)) i_fsktc_monitor (.clk, .resetn, .originatePin, .txSquelchPin,
    .loopbackSelectPin, .crystalSenseClampPin, .demodCarrierPin, .demodBandHigh, .loopRouteEn, .dacTap,
    .dacTapOe, .lineDriverEn, .rxBitOut, .rxBitOe, .carrierFoundN, .carrierFoundOe, .oscRunning);

// File: fsktc_far_model.sv
// far side: remote modem tone as the demodulator reports it
// assumes the bench commands carrier presence and the remote bit
`timescale 1ns/1ps
module fsktc_far_model (
    input  wire logic clk,
    input  wire logic carrierOn,
    input  wire logic remoteBit,
    output logic      demodBitPin,
    output logic      demodCarrierPin
);
    logic noise_q = 1'b0;
    // no carrier means noise on the bit line, never a held value
    always_ff @(posedge clk) noise_q <= !noise_q;
    assign demodCarrierPin = carrierOn;
    assign demodBitPin     = carrierOn ? remoteBit : noise_q;
endmodule

// File: fsktc_top_test.sv
// bench for the tone control top with a far side line model
// assumes divisors 10/8/5/4 and a baud count of 50
`timescale 1ns/1ps
module fsktc_top_test;
    logic        clk = 1'b0, resetn = 1'b0, txBitPin = 1'b0, originatePin = 1'b1;
    logic        txSquelchPin = 1'b1, loopbackSelectPin = 1'b0, crystalSenseClampPin = 1'b0;
    logic        carrierOn = 1'b0, remoteBit = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        demodBitPin, demodCarrierPin, demodBandHigh, loopRouteEn, dacTapOe;
    logic        lineDriverEn, rxBitOut, rxBitOe, carrierFoundN, carrierFoundOe;
    logic        oscRunning, hreadyout, hresp;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [15:0] dacTap;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    int          errors = 0, cmp_count = 0;
    // ----------------------------
    // clock, design and far side
    // ----------------------------
    always #4 clk = !clk;
    fsktc_top #(.DIV_OS(16'h000A), .DIV_OM(16'h0008), .DIV_AS(16'h0005), .DIV_AM(16'h0004),
        .BAUD_DIV(20'h00032)) i_fsktc_top (.clk, .resetn, .txBitPin, .originatePin, .txSquelchPin,
        .loopbackSelectPin, .crystalSenseClampPin, .demodBitPin, .demodCarrierPin, .demodBandHigh,
        .loopRouteEn, .dacTap, .dacTapOe, .lineDriverEn, .rxBitOut, .rxBitOe, .carrierFoundN,
        .carrierFoundOe, .oscRunning, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp);
    fsktc_far_model i_fsktc_far_model (.clk, .carrierOn, .remoteBit, .demodBitPin, .demodCarrierPin);
    // ----------------------------
    // shared tasks
    // ----------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // bounded wait for ready sampled high
    task automatic waitRdy(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            errors++;
            test_done;
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
                       output int n);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        waitRdy(n);
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy(n);
        r = hrdata;
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        int n;
        ahb(1'b0, a, 32'h0, r, n);
        check(r & m, e);
    endtask
    // pins pass two sync flops and an output flop
    task automatic setPins(input logic t, input logic o, input logic s, input logic l);
        @(posedge clk);
        txBitPin <= t;
        originatePin <= o;
        txSquelchPin <= s;
        loopbackSelectPin <= l;
        repeat (6) @(posedge clk);
    endtask
    task automatic nextTap(output logic [15:0] t, output int n);
        logic [15:0] p;
        p = dacTap;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dacTap === p && n < 400);
        if (n >= 400) begin
            errors++;
            test_done;
        end
        t = dacTap;
    endtask
    function automatic logic [15:0] tapOf(input int j);
        tapOf = 16'h0001 << fsktc_pkg::SINE_TABLE[4 * (j % 16) +: 4];
    endfunction
    // ----------------------------
    // scenarios
    // ----------------------------
    task automatic t_tone;
        logic [15:0] t, dv;
        int n;
        rdChk(32'h0, 32'hFF, 32'h0);
        rdChk(32'h10, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 4; i++) begin
            dv = i[1] ? (i[0] ? 16'h0008 : 16'h000A) : (i[0] ? 16'h0004 : 16'h0005);
            setPins(i[0], i[1], 1'b0, 1'b0);
            nextTap(t, n);
            nextTap(t, n);
            check(n, dv);
            check(demodBandHigh, i[1]);
            rdChk(32'hC, 32'hFFFF, {16'h0, dv});
        end
    endtask
    // a bit change mid-tone must carry the staircase on, not restart it
    task automatic t_coherent;
        logic [15:0] a, b, c;
        int n, k;
        setPins(1'b0, 1'b1, 1'b0, 1'b0);
        nextTap(a, n);
        nextTap(b, n);
        txBitPin <= 1'b1;
        nextTap(c, n);
        k = 0;
        for (int j = 1; j <= 16; j++) if (tapOf(j - 1) === a && tapOf(j) === b) k = j;
        check(c, tapOf(k + 1));
        nextTap(c, n);
        check(c, tapOf(k + 2));
    endtask
    task automatic t_modes;
        logic [31:0] r;
        int n;
        setPins(1'b0, 1'b1, 1'b1, 1'b0);
        check({dacTap, dacTapOe, lineDriverEn}, {16'h0100, 2'b11});
        rdChk(32'h4, 32'hF, 32'h2);
        carrierOn <= 1'b1;
        setPins(1'b0, 1'b1, 1'b0, 1'b0);
        check(rxBitOut, 1'b0);
        remoteBit <= 1'b1;
        repeat (6) @(posedge clk);
        check(rxBitOut, 1'b1);
        carrierOn <= 1'b0;
        repeat (6) @(posedge clk);
        check(rxBitOut, 1'b1);
        setPins(1'b0, 1'b1, 1'b0, 1'b1);
        check({carrierFoundN, carrierFoundOe, loopRouteEn, demodBandHigh}, 4'b0110);
        check({dacTapOe, lineDriverEn}, 2'b11);
        repeat (100) @(posedge clk);
        check(rxBitOut, 1'b0);
        txBitPin <= 1'b1;
        repeat (100) @(posedge clk);
        check(rxBitOut, 1'b1);
        setPins(1'b0, 1'b1, 1'b1, 1'b1);
        check({dacTapOe, rxBitOe, carrierFoundOe, lineDriverEn, oscRunning}, 5'b00001);
        ahb(1'b0, 32'h4, 32'h0, r, n);
        repeat (40) @(posedge clk);
        rdChk(32'h4, 32'h10FF, {24'h000010, r[7:4], 4'h8});
        crystalSenseClampPin <= 1'b1;
        repeat (6) @(posedge clk);
        check(oscRunning, 1'b0);
        crystalSenseClampPin <= 1'b0;
    endtask
    // stream mode: fill the buffer until the bus stalls, then drain it
    task automatic t_buffer;
        logic [31:0] r;
        int n, worst;
        setPins(1'b0, 1'b1, 1'b0, 1'b0);
        ahb(1'b1, 32'h0, 32'h20, r, n);
        worst = 0;
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, 32'h8, {31'h0, i[0]}, r, n);
            if (n > worst) worst = n;
        end
        check(worst > 2, 1'b1);
        rdChk(32'h4, 32'hC00, 32'h800);
        repeat (150) @(posedge clk);
        rdChk(32'h4, 32'hC00, 32'h0);
        check(hresp, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_tone;
        t_coherent;
        t_modes;
        t_buffer;
        test_done;
    end
endmodule
